// >>> panel_consts.svh
/*
 * Offsets, field positions, reset values and timing counts for the
 * front-panel menu controller. Definitions only; included by the controller
 * module and by the testbench.
 */
`ifndef PANEL_CONSTS_SVH
`define PANEL_CONSTS_SVH

// clock and timing figures in their own units
`define CLK_HZ           20000000
`define BL_TIMEOUT_S     5
`define SETTLE_S         3
`define DEBOUNCE_MS      1
`define TONE_HZ          1000
`define TONE_STEPS       16
`define TONE_STEP_CYC    (`CLK_HZ / (`TONE_HZ * `TONE_STEPS))

// register byte offsets
`define OFS_CTRL         8'h00
`define OFS_STATUS       8'h04
`define OFS_TEMP         8'h08
`define OFS_LEVEL        8'h0c

// settings byte fields (control register and stored image)
`define F_RANGE_LSB      0
`define F_BAND_LSB       2
`define F_BASS           4
`define F_LASER          5
`define F_SIG_LSB        6
`define NVM_SIG          2'h2
`define SET_DEFAULT      8'ha0

// analog codes: 94 percent and 99 percent of full scale, then the three inner tone steps
`define OVR_THRESH       24'h7851eb
`define TONE_PEAK        24'h7eb851
`define TONE_S1          24'h307e40
`define TONE_S2          24'h599b00
`define TONE_S3          24'h751270

`endif

// >>> panel_pkg.sv
/*
 * Types for the front-panel menu controller: screens, settings fields.
 * Assumes panel_consts.svh provides the numeric constants.
 */
package panel_pkg;
   typedef enum logic [6:0] {
      SCR_START   = 7'b0000001,
      SCR_MAIN    = 7'b0000010,
      SCR_LAS_ON  = 7'b0000100,
      SCR_LAS_OFF = 7'b0001000,
      SCR_TEMP    = 7'b0010000,
      SCR_FULL    = 7'b0100000,
      SCR_ZERO    = 7'b1000000
   } screen_e;
   typedef logic [1:0]  range_t;   // 0: 20, 1: 100, 2: 500 mm/s
   typedef logic [1:0]  band_t;    // 0: off, 1: 1k, 2: 5k, 3: 22k
   typedef logic [23:0] sample_t;
endpackage : panel_pkg

// >>> panel_menu_ctrl.sv
/*
 * Front-panel menu controller: two keys, start screen, main menu, service
 * mode, backlight timeout, settings persistence, overrange and level bar,
 * with an AXI4-Lite register slave. Assumes keys and analog samples are
 * synchronous to clk_i and that the settings memory returns its stored byte
 * on nvm_rdata_i from reset release onward.
 */
// Functional notes
// - backlight off after 5 s without keys
// - selection key advances cursor, wraps around
// - change key steps selected value
// - new value applies next cycle, unconfirmed
// - settings saved and restored across power
// - start screen during settling, then main
// - any key ends start screen early
// - main menu: range, band limit, bass cut
// - service screens cycle through five entries
// - leaving service keeps laser state
// - selection key leaves service mode
// - temperature shown in tenths of degree
// - full test tone 1 kHz, 99 percent
// - tone only while its screen shown
// - zero output only on zero screen
// - overrange lit while range exceeded
// - level bar grows with returned light
// - ranges 20, 100, 500 mm/s
// - band limit 1k, 5k, 22k or off
// - overrange at 94 percent full scale
`timescale 1ns/1ns
`include "panel_consts.svh"

module panel_menu_ctrl #(
   parameter int unsigned BL_CYC     = `BL_TIMEOUT_S * `CLK_HZ,
   parameter int unsigned SETTLE_CYC = `SETTLE_S * `CLK_HZ,
   parameter int unsigned DEB_CYC    = `DEBOUNCE_MS * (`CLK_HZ / 1000)
) (
   input  wire logic             clk_i,          // 20 MHz system clock
   input  wire logic             rstn_i,         // async reset, active low
   input  wire logic             key_sel_i,      // selection key, high pressed
   input  wire logic             key_chg_i,      // change key, high pressed
   input  wire panel_pkg::sample_t signal_i,     // velocity sample, signed
   input  wire logic [7:0]       light_i,        // returned light level
   input  wire logic [11:0]      temp_i,         // temperature, 1/16 degC
   input  wire logic [7:0]       nvm_rdata_i,    // stored settings byte
   output logic                  nvm_wr_o,       // store pulse
   output logic [7:0]            nvm_wdata_o,    // byte to store
   output panel_pkg::screen_e    screen_o,       // screen shown
   output logic [1:0]            cursor_o,       // main menu cursor
   output panel_pkg::range_t     range_o,        // velocity range
   output panel_pkg::band_t      upper_band_limit_o, // digital filter
   output logic                  bass_cut_filter_on_o, // analog filter
   output logic                  laser_on_o,     // laser enable
   output logic                  backlight_o,    // backlight enable
   output logic                  overrange_o,    // overrange indicator
   output logic [7:0]            level_bar_o,    // level bar segments
   output logic [15:0]           temp_tenths_o,  // temperature, 0.1 degC
   output panel_pkg::sample_t    aout_o,         // analog output code
   input  wire logic [7:0]       s_axi_awaddr,   // write address
   input  wire logic             s_axi_awvalid,  // write address valid
   output logic                  s_axi_awready,  // write address ready
   input  wire logic [31:0]      s_axi_wdata,    // write data
   input  wire logic [3:0]       s_axi_wstrb,    // write strobes
   input  wire logic             s_axi_wvalid,   // write data valid
   output logic                  s_axi_wready,   // write data ready
   output logic [1:0]            s_axi_bresp,    // write response
   output logic                  s_axi_bvalid,   // write response valid
   input  wire logic             s_axi_bready,   // write response ready
   input  wire logic [7:0]       s_axi_araddr,   // read address
   input  wire logic             s_axi_arvalid,  // read address valid
   output logic                  s_axi_arready,  // read address ready
   output logic [31:0]           s_axi_rdata,    // read data
   output logic [1:0]            s_axi_rresp,    // read response
   output logic                  s_axi_rvalid,   // read data valid
   input  wire logic             s_axi_rready    // read data ready
);
   import panel_pkg::*;

   localparam int unsigned TONE_CYC = `TONE_STEP_CYC;

   // register decode shared by read and write paths
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == `OFS_CTRL) || (a == `OFS_STATUS) ||
                (a == `OFS_TEMP) || (a == `OFS_LEVEL);
   endfunction : reg_hit

   // one period of the test tone, quarter wave mirrored
   function automatic sample_t tone_lut(input logic [3:0] i);
      logic [2:0] q;
      sample_t    m;
      q = i[2] ? 3'(4 - {1'b0, i[1:0]}) : {1'b0, i[1:0]};
      unique case (q)
         3'h0: m = 24'h000000;
         3'h1: m = `TONE_S1;
         3'h2: m = `TONE_S2;
         3'h3: m = `TONE_S3;
         default: m = `TONE_PEAK;
      endcase
      tone_lut = i[3] ? 24'(-m) : m;
   endfunction : tone_lut

   screen_e     scr_ff;
   logic [1:0]  cursor_ff;
   logic [7:0]  set_ff;          // range, band, bass, laser packed
   logic [7:0]  last_ff;
   logic        loaded_ff;
   logic [26:0] settle_ff;
   logic [26:0] idle_ff;
   logic [3:0]  tone_idx_ff;
   logic [10:0] tone_cnt_ff;
   logic [1:0]  held;
   logic [1:0]  press;
   logic        sel_p;
   logic        chg_p;
   logic        svc;
   logic [23:0] mag;

   for (genvar g = 0; g < 2; g++) begin : g_key
      logic [26:0] cnt_ff;
      logic        stab_ff;
      logic        prev_ff;
      wire         raw = (g == 0) ? key_sel_i : key_chg_i;
      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            cnt_ff  <= 27'h0;
            stab_ff <= 1'b0;
            prev_ff <= 1'b0;
         end else begin
            prev_ff <= stab_ff;
            if (raw == stab_ff) begin
               cnt_ff <= 27'h0;
            end else if (cnt_ff == 27'(DEB_CYC - 1)) begin
               cnt_ff  <= 27'h0;
               stab_ff <= raw;
            end else begin
               cnt_ff <= cnt_ff + 27'h1;
            end
         end
      end
      assign held[g]  = stab_ff;
      assign press[g] = stab_ff & ~prev_ff;
   end

   assign sel_p = press[0];
   assign chg_p = press[1];
   assign svc   = (scr_ff != SCR_START) && (scr_ff != SCR_MAIN);

   // startup settling timer
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         settle_ff <= 27'h0;
      end else if (scr_ff == SCR_START) begin
         settle_ff <= settle_ff + 27'h1;
      end
   end

   // screen state: start, main, service screens
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         scr_ff <= SCR_START;
      end else begin
         unique case (scr_ff)
            SCR_START: if (sel_p || chg_p || settle_ff == 27'(SETTLE_CYC - 1)) begin
               scr_ff <= SCR_MAIN;
            end
            SCR_MAIN: if (sel_p && held[1]) begin
               scr_ff <= SCR_TEMP;
            end
            default: begin
               if (sel_p) begin
                  scr_ff <= SCR_MAIN;
               end else if (chg_p) begin
                  unique case (scr_ff)
                     SCR_LAS_ON:  scr_ff <= SCR_LAS_OFF;
                     SCR_LAS_OFF: scr_ff <= SCR_TEMP;
                     SCR_TEMP:    scr_ff <= SCR_FULL;
                     SCR_FULL:    scr_ff <= SCR_ZERO;
                     default:     scr_ff <= SCR_LAS_ON;
                  endcase
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cursor_ff <= 2'h0;
      end else if (scr_ff == SCR_MAIN && sel_p && !held[1]) begin
         cursor_ff <= (cursor_ff == 2'h2) ? 2'h0 : cursor_ff + 2'h1;
      end
   end

   // settings: restore, key steps, service laser, software writes
   logic       s_axi_bvalid_set;
   logic [5:0] wd_ff;            // write data held after its handshake
   logic       ws_ff;            // low byte strobe held likewise
   wire        wr_go = s_axi_bvalid_set;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         set_ff    <= `SET_DEFAULT;
         loaded_ff <= 1'b0;
      end else if (!loaded_ff) begin
         loaded_ff <= 1'b1;
         if (nvm_rdata_i[7:6] == `NVM_SIG && nvm_rdata_i[1:0] != 2'h3) begin
            set_ff <= nvm_rdata_i;
         end
      end else if (scr_ff == SCR_MAIN && chg_p && !sel_p) begin
         unique case (cursor_ff)
            2'h0: set_ff[1:0] <= (set_ff[1:0] == 2'h2) ? 2'h0 : set_ff[1:0] + 2'h1;
            2'h1: set_ff[3:2] <= set_ff[3:2] + 2'h1;
            default: set_ff[`F_BASS] <= ~set_ff[`F_BASS];
         endcase
      // laser follows the last service choice
      end else if (scr_ff == SCR_LAS_ON) begin
         set_ff[`F_LASER] <= 1'b1;
      end else if (scr_ff == SCR_LAS_OFF) begin
         set_ff[`F_LASER] <= 1'b0;
      end else if (wr_go && ws_ff && wd_ff[1:0] != 2'h3) begin
         set_ff[5:0] <= wd_ff;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         last_ff     <= `SET_DEFAULT;
         nvm_wr_o    <= 1'b0;
         nvm_wdata_o <= `SET_DEFAULT;
      end else begin
         last_ff     <= set_ff;
         nvm_wr_o    <= loaded_ff && (set_ff != last_ff);
         nvm_wdata_o <= set_ff;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         idle_ff     <= 27'h0;
         backlight_o <= 1'b1;
      end else if (sel_p || chg_p) begin
         idle_ff     <= 27'h0;
         backlight_o <= 1'b1;
      end else if (idle_ff == 27'(BL_CYC - 1)) begin
         backlight_o <= 1'b0;
      end else begin
         idle_ff <= idle_ff + 27'h1;
      end
   end

   // tone phase runs only on its screen
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tone_cnt_ff <= 11'h0;
         tone_idx_ff <= 4'h0;
      end else if (scr_ff != SCR_FULL) begin
         tone_cnt_ff <= 11'h0;
         tone_idx_ff <= 4'h0;
      end else if (tone_cnt_ff == 11'(TONE_CYC - 1)) begin
         tone_cnt_ff <= 11'h0;
         tone_idx_ff <= tone_idx_ff + 4'h1;
      end else begin
         tone_cnt_ff <= tone_cnt_ff + 11'h1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aout_o <= 24'h000000;
      end else if (scr_ff == SCR_FULL) begin
         aout_o <= tone_lut(tone_idx_ff);
      end else if (scr_ff == SCR_ZERO) begin
         aout_o <= 24'h000000;
      end else begin
         aout_o <= signal_i;
      end
   end

   assign mag = signal_i[23] ? 24'(-signal_i) : signal_i;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         overrange_o <= 1'b0;
      end else begin
         overrange_o <= (mag >= `OVR_THRESH);
      end
   end

   // level bar, one segment per 32 steps of light
   for (genvar s = 0; s < 8; s++) begin : g_bar
      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            level_bar_o[s] <= 1'b0;
         end else begin
            level_bar_o[s] <= (light_i[7:5] >= 3'(s)) && (light_i != 8'h00);
         end
      end
   end

   // temperature to tenths of a degree
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         temp_tenths_o <= 16'h0000;
      end else begin
         temp_tenths_o <= 16'(($signed({{4{temp_i[11]}}, temp_i}) * 16'sd10) >>> 4);
      end
   end

   // settings drive the measurement path directly
   assign range_o              = set_ff[1:0];
   assign upper_band_limit_o   = set_ff[3:2];
   assign bass_cut_filter_on_o = set_ff[`F_BASS];
   assign laser_on_o           = set_ff[`F_LASER];
   assign screen_o             = scr_ff;
   assign cursor_o             = cursor_ff;

   // axi write: take address and data in any order, answer after both
   logic       aw_ff;
   logic       w_ff;
   logic [7:0] awa_ff;
   assign s_axi_awready    = !aw_ff && !s_axi_bvalid;
   assign s_axi_wready     = !w_ff && !s_axi_bvalid;
   assign s_axi_bvalid_set = aw_ff && w_ff && !s_axi_bvalid && awa_ff == `OFS_CTRL;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aw_ff        <= 1'b0;
         w_ff         <= 1'b0;
         awa_ff       <= 8'h00;
         wd_ff        <= 6'h00;
         ws_ff        <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else if (s_axi_bvalid) begin
         if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end else if (aw_ff && w_ff) begin
         aw_ff        <= 1'b0;
         w_ff         <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= reg_hit(awa_ff) ? 2'h0 : 2'h2;
      end else begin
         if (s_axi_awvalid && !aw_ff) begin
            aw_ff  <= 1'b1;
            awa_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_ff) begin
            w_ff  <= 1'b1;
            wd_ff <= s_axi_wdata[5:0];
            ws_ff <= s_axi_wstrb[0];
         end
      end
   end

   // axi read: one beat, answer the cycle after the address
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else if (s_axi_arvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= reg_hit(s_axi_araddr) ? 2'h0 : 2'h2;
         unique case (s_axi_araddr)
            `OFS_CTRL:   s_axi_rdata <= {26'h0, set_ff[5:0]};
            `OFS_STATUS: s_axi_rdata <= {19'h0, laser_on_o, backlight_o, overrange_o,
                                         cursor_ff, 1'b0, scr_ff};
            `OFS_TEMP:   s_axi_rdata <= {{16{temp_tenths_o[15]}}, temp_tenths_o};
            `OFS_LEVEL:  s_axi_rdata <= {24'h0, level_bar_o};
            default:     s_axi_rdata <= 32'h0;
         endcase
      end
   end

   // checks on the menu behaviour
   sequence svc_entry_s;
      scr_ff == SCR_MAIN && held[1] && sel_p;
   endsequence
   sequence svc_exit_s;
      svc && sel_p;
   endsequence

   bl_timeout_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $fell(backlight_o) |-> $past(idle_ff) == 27'(BL_CYC - 1))
      else $error("backlight dropped before idle limit");
   cursor_wrap_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      scr_ff == SCR_MAIN && sel_p && !held[1] && cursor_ff == 2'h2 |=> cursor_ff == 2'h0)
      else $error("cursor did not wrap");
   range_step_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      scr_ff == SCR_MAIN && chg_p && !sel_p && cursor_ff == 2'h0 && loaded_ff
      |=> range_o == (($past(range_o) == 2'h2) ? 2'h0 : $past(range_o) + 2'h1))
      else $error("range did not step");
   bass_apply_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      scr_ff == SCR_MAIN && chg_p && !sel_p && cursor_ff == 2'h2 && loaded_ff
      |=> bass_cut_filter_on_o != $past(bass_cut_filter_on_o) ##1 nvm_wr_o)
      else $error("bass filter change not applied or stored");
   start_end_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      scr_ff == SCR_START && (sel_p || chg_p) |=> scr_ff == SCR_MAIN)
      else $error("start screen not ended by key");
   svc_enter_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      svc_entry_s |=> scr_ff == SCR_TEMP)
      else $error("service mode not entered");
   svc_ring_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      scr_ff == SCR_ZERO && chg_p && !sel_p |=> scr_ff == SCR_LAS_ON ##1 laser_on_o)
      else $error("service ring or laser on broken");
   laser_keep_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      svc_exit_s ##1 scr_ff == SCR_MAIN |-> laser_on_o == $past(laser_on_o))
      else $error("laser changed on service exit");
   zero_out_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      scr_ff == SCR_ZERO |=> aout_o == 24'h000000)
      else $error("zero screen output not zero");
   over_ind_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      overrange_o == $past(mag >= `OVR_THRESH))
      else $error("overrange indicator mismatch");
endmodule : panel_menu_ctrl

// >>> panel_key_operator.sv
/*
 * Operator model for the two front-panel keys, with contact bounce.
 * Assumes a free-running clock; keys read high while pressed.
 */
`timescale 1ns/1ns
module panel_key_operator #(
   parameter int unsigned DEB = 4      // panel filter length in cycles
) (
   input  wire logic clk_i,            // system clock
   output logic      key_sel_o,        // selection key
   output logic      key_chg_o         // change key
);
   // both keys start released
   initial begin
      key_sel_o = 1'b0;
      key_chg_o = 1'b0;
   end
   // move one key right after an edge
   task automatic set_key(input bit sel, input logic v);
      @(posedge clk_i);
      if (sel) key_sel_o <= v;
      else key_chg_o <= v;
   endtask : set_key
   // one bounce shorter than the filter, then a settled level
   task automatic hold(input bit sel, input logic v);
      set_key(sel, v);
      set_key(sel, ~v);
      set_key(sel, v);
      repeat (DEB + 4) @(posedge clk_i);
   endtask : hold
   // a whole press and release
   task automatic tap(input bit sel);
      hold(sel, 1'b1);
      hold(sel, 1'b0);
   endtask : tap
   task automatic combo();
      hold(1'b0, 1'b1);
      tap(1'b1);
      hold(1'b0, 1'b0);
   endtask : combo
endmodule : panel_key_operator

// >>> front_panel_menu_controller_tb_top.sv
/*
 * Self-checking bench for the front-panel menu controller.
 * Assumes short timing parameters and the operator model for the keys.
 */
`timescale 1ns/1ns
`include "panel_consts.svh"
module front_panel_menu_controller_tb_top;
   import panel_pkg::*;
   localparam int unsigned DEB = 4;
   localparam int unsigned BL  = 200;
   localparam int unsigned STL = 100;
   logic       clk_i, rstn_i, ksel, kchg, nvm_wr, bass, laser, bl, ovr;
   logic       awv, awr, wv, wrd, bv, brdy, arv, arr, rv, rrdy;
   logic [1:0] cur, bresp, rresp, resp;
   range_t     rg;
   band_t      bd;
   screen_e    scr;
   sample_t    sig, aout;
   logic [7:0] light, nvm_rd, nvm_wd, bar, awa, ara;
   logic [11:0] temp;
   logic [15:0] tenths;
   logic [31:0] wd, rdata, rd;
   int         failures, compares, nwr;
   sample_t    corner [4] = '{24'h7851eb, 24'h7851ea, 24'h87ae15, 24'h800000};

   panel_key_operator #(.DEB(DEB)) i_panel_key_operator (.clk_i(clk_i), .key_sel_o(ksel),
      .key_chg_o(kchg));
   panel_menu_ctrl #(.BL_CYC(BL), .SETTLE_CYC(STL), .DEB_CYC(DEB)) i_panel_menu_ctrl (
      .clk_i(clk_i), .rstn_i(rstn_i), .key_sel_i(ksel), .key_chg_i(kchg), .signal_i(sig),
      .light_i(light), .temp_i(temp), .nvm_rdata_i(nvm_rd), .nvm_wr_o(nvm_wr),
      .nvm_wdata_o(nvm_wd), .screen_o(scr), .cursor_o(cur), .range_o(rg),
      .upper_band_limit_o(bd), .bass_cut_filter_on_o(bass), .laser_on_o(laser),
      .backlight_o(bl), .overrange_o(ovr), .level_bar_o(bar), .temp_tenths_o(tenths),
      .aout_o(aout), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rrdy));

   // 50 ns clock
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // count store pulses
   always @(posedge clk_i) if (nvm_wr === 1'b1) nwr <= nwr + 1;

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic tap(input bit s);
      i_panel_key_operator.tap(s);
   endtask : tap
   task automatic do_reset(input logic [7:0] b);
      rstn_i <= 1'b0;
      nvm_rd <= b;
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (2) @(posedge clk_i);
   endtask : do_reset
   // write: each channel dropped once taken, answer sampled at its edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw, w, b;
      @(posedge clk_i);
      awa <= a;
      wd <= d;
      {awv, wv, brdy} <= 3'b111;
      do begin
         @(negedge clk_i);
         aw = awv & awr;
         w = wv & wrd;
         b = bv;
         r = bresp;
         @(posedge clk_i);
         if (aw) awv <= 1'b0;
         if (w) wv <= 1'b0;
      end while (!b);
      brdy <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [1:0] r, output logic [31:0] d);
      bit ar, v;
      @(posedge clk_i);
      ara <= a;
      {arv, rrdy} <= 2'b11;
      do begin
         @(negedge clk_i);
         ar = arv & arr;
         v = rv;
         r = rresp;
         d = rdata;
         @(posedge clk_i);
         if (ar) arv <= 1'b0;
      end while (!v);
      rrdy <= 1'b0;
   endtask : axi_rd
   function automatic logic [31:0] tenths_of(input logic [11:0] t);
      int v;
      v = $signed(t);
      v = (v * 10) >>> 4;
      return {16'h0000, v[15:0]};
   endfunction : tenths_of
   function automatic logic over_of(input sample_t s);
      sample_t m;
      m = s[23] ? -s : s;
      return m >= `OVR_THRESH;
   endfunction : over_of
   function automatic logic [7:0] bar_of(input logic [7:0] l);
      logic [7:0] b;
      for (int s = 0; s < 8; s++) b[s] = (l != 8'h00) && (l[7:5] >= s);
      return b;
   endfunction : bar_of
   task automatic report_and_stop();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop

   // main sequence
   initial begin
      int n;
      logic [5:0] m;
      void'($urandom(32'ha528));
      {awv, wv, brdy, arv, rrdy} = '0;
      {awa, ara, wd, sig, light, temp, nvm_rd} = '0;
      rstn_i = 1'b0;
      do_reset(8'h96);
      chk("restored", 6'h16, {laser, bass, bd, rg});
      chk("screen", SCR_START, scr);
      repeat (STL + 4) @(posedge clk_i);
      chk("screen", SCR_MAIN, scr);
      do_reset(8'h43);
      chk("defaults", 6'h20, {laser, bass, bd, rg});
      tap(1'b1);
      chk("screen", SCR_MAIN, scr);
      chk("cursor", 0, cur);
      $display("test start done");
      m = 6'h20;
      for (int p = 0; p < 3; p++) begin
         for (int k = 0; k < 4; k++) begin
            n = nwr;
            tap(1'b0);
            if (p == 0) m[1:0] = (m[1:0] == 2'd2) ? 2'd0 : m[1:0] + 2'd1;
            if (p == 1) m[3:2] = m[3:2] + 2'd1;
            if (p == 2) m[4] = ~m[4];
            chk("settings", m, {laser, bass, bd, rg});
            chk("stored", {2'h2, m}, nvm_wd);
            chk("writes", n + 1, nwr);
         end
         tap(1'b1);
         chk("cursor", (p + 1) % 3, cur);
      end
      $display("test menu done");
      i_panel_key_operator.combo();
      chk("screen", SCR_TEMP, scr);
      for (int i = 0; i < 4; i++) begin
         temp <= (i == 0) ? 12'h800 : 12'($urandom);
         repeat (3) @(posedge clk_i);
         chk("tenths", tenths_of(temp), tenths);
      end
      tap(1'b0);
      chk("screen", SCR_FULL, scr);
      n = 0;
      while (aout !== `TONE_PEAK && n < 20000) begin
         @(posedge clk_i);
         n++;
      end
      chk("tone", `TONE_PEAK, aout);
      tap(1'b0);
      sig <= 24'h400000;
      repeat (3) @(posedge clk_i);
      chk("zero", 0, aout);
      tap(1'b0);
      chk("laser", 1, laser);
      tap(1'b0);
      chk("laser", 0, laser);
      tap(1'b0);
      chk("screen", SCR_TEMP, scr);
      tap(1'b1);
      chk("screen", SCR_MAIN, scr);
      chk("laser", 0, laser);
      $display("test service done");
      for (int i = 0; i < 40; i++) begin
         sig <= (i < 4) ? corner[i] : 24'($urandom);
         light <= (i == 0) ? 8'h00 : 8'($urandom);
         repeat (3) @(posedge clk_i);
         chk("overrange", over_of(sig), ovr);
         chk("level", bar_of(light), bar);
         chk("aout", sig, aout);
      end
      tap(1'b1);
      repeat (BL - 40) @(posedge clk_i);
      chk("backlight", 1, bl);
      repeat (60) @(posedge clk_i);
      chk("backlight", 0, bl);
      $display("test signal done");
      axi_wr(8'h00, 32'h19, resp);
      chk("bresp", 0, resp);
      chk("settings", 6'h19, {laser, bass, bd, rg});
      axi_rd(8'h00, resp, rd);
      chk("ctrl", 32'h19, rd);
      axi_wr(8'h00, 32'h03, resp);
      chk("range kept", 6'h19, {laser, bass, bd, rg});
      axi_rd(8'h04, resp, rd);
      chk("status", SCR_MAIN, rd[6:0]);
      axi_rd(8'h40, resp, rd);
      chk("rresp", 2, resp);
      axi_wr(8'h40, 32'h0, resp);
      chk("bresp", 2, resp);
      $display("test bus done");
      report_and_stop();
   end
   // watchdog cuts a hang short
   initial begin
      repeat (60000) @(posedge clk_i);
      failures++;
      $display("CHECK FAILED watchdog expected end seen timeout");
      report_and_stop();
   end
endmodule : front_panel_menu_controller_tb_top
